//--- common/icc_pkg.sv
// shared constants, types and register map for the input correction chain
`default_nettype none
package icc_pkg;
    localparam int DATA_W   = 16;
    localparam int ADDR_W   = 8;
    localparam int DIV_W    = 40;
    localparam int SQ_W     = 18;
    localparam int FRAC_W   = 8;
    localparam int FIFO_DEPTH = 8;

    // register offsets
    localparam logic [7:0] OFS_BIAS   = 8'hab;
    localparam logic [7:0] OFS_FILT   = 8'hac;
    localparam logic [7:0] OFS_KX1    = 8'had;
    localparam logic [7:0] OFS_KY1    = 8'hae;
    localparam logic [7:0] OFS_KX2    = 8'haf;
    localparam logic [7:0] OFS_KY2    = 8'hb0;
    localparam logic [7:0] OFS_KX3    = 8'hb1;
    localparam logic [7:0] OFS_KY3    = 8'hb2;
    localparam logic [7:0] OFS_ROOT   = 8'hb3;
    localparam logic [7:0] OFS_CUT    = 8'hb4;
    localparam logic [7:0] OFS_SLOW   = 8'hb5;
    localparam logic [7:0] OFS_SHIGH  = 8'hb6;
    localparam logic [7:0] OFS_ITYPE  = 8'hb7;
    localparam logic [7:0] OFS_PV     = 8'hb8;
    localparam logic [7:0] OFS_STAT   = 8'hb9;

    // reset values
    localparam logic [15:0] RST_SLOW  = 16'h0000;
    localparam logic [15:0] RST_SHIGH = 16'h2710;
    localparam logic [15:0] RST_CUT   = 16'h0064;
    localparam logic [15:0] RST_ZERO  = 16'h0000;

    // percentages of span as divisors: 5 % and 1 %
    localparam int PCT5_DIV = 20;
    localparam int PCT1_DIV = 100;

    // filter time base
    localparam int FILT_MAX_S     = 120;
    localparam int MS_PER_S       = 1000;
    localparam int SAMPLE_MS      = 200;

    typedef enum logic [1:0] {
        ITYPE_TC  = 2'b00,
        ITYPE_RTD = 2'b01,
        ITYPE_DCV = 2'b10
    } icc_itype_e;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_SEG  = 3'b001,
        ST_DIV  = 3'b010,
        ST_ADD  = 3'b011,
        ST_ROOT = 3'b100,
        ST_FILT = 3'b101,
        ST_OUT  = 3'b110
    } icc_state_e;

    typedef struct packed {
        logic [15:0] bias;
        logic [15:0] filt;
        logic [15:0] kx1;
        logic [15:0] ky1;
        logic [15:0] kx2;
        logic [15:0] ky2;
        logic [15:0] kx3;
        logic [15:0] ky3;
        logic [15:0] root;
        logic [15:0] cut;
        logic [15:0] slow;
        logic [15:0] shigh;
        logic [1:0]  itype;
    } icc_cfg_s;
endpackage
`default_nettype wire

//--- src/icc_input_correction_chain.sv
// input correction chain: sample fifo, broken-line and fixed bias, root, lag filter
//
// What this block does
// - each sample gets a bias read off a three-point broken line.
// - knee inputs are held to -5 %..105 % of span (reset low limit), knee biases to +-span (reset 0).
// - a constant bias of +-span, reset 0, is added to every sample.
// - root extraction runs only when its setting is 1; 0, the reset value, passes the value.
// - values below the low-cut threshold (0..5 % of span, reset 1 %) skip extraction.
// - root extraction happens only for dc voltage input, never thermocouple or rtd.
// - the result is smoothed by a first-order lag with a programmable time constant.
// - time constant 0 bypasses the filter; 1..120 s filter harder as the value grows.
// - span limits derive from the scale low and upper limits.
//
// Strobed register access was chosen for this implementation.
`default_nettype none

module icc_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 8
) (
    // clock and reset
    input  wire logic             clk_in,
    input  wire logic             reset_in,
    // fill side
    input  wire logic [WIDTH-1:0] in_data_in,
    input  wire logic             in_valid_in,
    output logic                  in_ready_out,
    // drain side
    output logic [WIDTH-1:0]      out_data_out,
    output logic                  out_valid_out,
    input  wire logic             out_ready_in
);
    localparam int PW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW-1:0]    wr_ptr_q;
    logic [PW-1:0]    rd_ptr_q;
    logic [CW-1:0]    cnt_q;
    logic [CW-1:0]    cnt_d;
    logic             push;
    logic             pop;

    assign push = in_valid_in & in_ready_out;
    assign pop  = out_valid_out & out_ready_in;
    assign out_data_out = mem[rd_ptr_q];

    always_comb
    begin
        cnt_d = cnt_q;
        if (push & ~pop)
        begin
            cnt_d = cnt_q + CW'(1);
        end
        else if (pop & ~push)
        begin
            cnt_d = cnt_q - CW'(1);
        end
    end

    always_ff @(posedge clk_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            wr_ptr_q      <= '0;
            rd_ptr_q      <= '0;
            cnt_q         <= '0;
            in_ready_out  <= 1'b0;
            out_valid_out <= 1'b0;
        end
        else
        begin
            cnt_q         <= cnt_d;
            in_ready_out  <= (cnt_d != CW'(DEPTH));
            out_valid_out <= (cnt_d != '0);
            if (push)
            begin
                wr_ptr_q <= (wr_ptr_q == PW'(DEPTH - 1)) ? '0 : wr_ptr_q + PW'(1);
            end
            if (pop)
            begin
                rd_ptr_q <= (rd_ptr_q == PW'(DEPTH - 1)) ? '0 : rd_ptr_q + PW'(1);
            end
        end
    end

    always_ff @(posedge clk_in)
    begin
        if (push)
        begin
            mem[wr_ptr_q] <= in_data_in;
        end
    end
endmodule // icc_fifo

module icc_input_correction_chain (
    // clock and reset
    input  wire logic        clk_in,
    input  wire logic        reset_in,
    // register port
    input  wire logic [7:0]  reg_addr_in,
    input  wire logic [15:0] reg_wdata_in,
    input  wire logic        reg_wr_in,
    input  wire logic        reg_rd_in,
    output logic [15:0]      reg_rdata_out,
    // sensor samples
    input  wire logic [15:0] smp_data_in,
    input  wire logic        smp_valid_in,
    output logic             smp_ready_out,
    // process value
    output logic [15:0]      pv_out,
    output logic             pv_valid_out
);
    localparam int DW = icc_pkg::DIV_W;
    localparam int FW = icc_pkg::FRAC_W;

    icc_pkg::icc_cfg_s   cfg_q;
    icc_pkg::icc_state_e st_q;

    logic [15:0]        fifo_data;
    logic               fifo_valid;
    logic               fifo_pop;
    logic signed [17:0] span;
    logic signed [17:0] pct5;
    logic signed [17:0] wr_lo;
    logic signed [17:0] wr_hi;
    logic signed [17:0] wr_val;
    logic [15:0]        wr_clamped;
    logic signed [DW-1:0] x_q;
    logic signed [DW-1:0] val_q;
    logic signed [DW-1:0] acc_q;
    logic [DW-1:0]      div_num_q;
    logic [DW-1:0]      div_den_q;
    logic [DW-1:0]      div_rem_q;
    logic [DW-1:0]      div_trial;
    logic [5:0]         div_cnt_q;
    logic               div_neg_q;
    logic               div_filt_q;
    logic signed [DW-1:0] div_quo;
    logic [35:0]        sq_op_q;
    logic [17:0]        sq_res_q;
    logic [17:0]        sq_try;
    logic [4:0]         sq_bit_q;
    logic signed [DW-1:0] xa;
    logic signed [DW-1:0] xb;
    logic signed [DW-1:0] ya;
    logic signed [DW-1:0] yb;
    logic signed [DW-1:0] prod;
    logic signed [DW-1:0] sum;
    logic signed [DW-1:0] rel;
    logic signed [DW-1:0] fdiff;

    function automatic logic signed [DW-1:0] sx(input logic [15:0] v);
        return DW'(signed'(v));
    endfunction

    function automatic logic [15:0] sat16(input logic signed [DW-1:0] v);
        if (v > sx(16'h7fff))
        begin
            return 16'h7fff;
        end
        if (v < sx(16'h8000))
        begin
            return 16'h8000;
        end
        return v[15:0];
    endfunction

    icc_fifo #(
        .WIDTH (16),
        .DEPTH (icc_pkg::FIFO_DEPTH)
    ) u_fifo (
        .clk_in        (clk_in),
        .reset_in      (reset_in),
        .in_data_in    (smp_data_in),
        .in_valid_in   (smp_valid_in),
        .in_ready_out  (smp_ready_out),
        .out_data_out  (fifo_data),
        .out_valid_out (fifo_valid),
        .out_ready_in  (fifo_pop)
    );

    assign fifo_pop = (st_q == icc_pkg::ST_IDLE);

    // write range limits from the scale span
    always_comb
    begin
        span   = 18'(signed'(cfg_q.shigh)) - 18'(signed'(cfg_q.slow));
        pct5   = span / 18'sd20;
        wr_val = 18'(signed'(reg_wdata_in));
        wr_lo  = 18'sh20000;
        wr_hi  = 18'sh1ffff;
        unique case (reg_addr_in)
            icc_pkg::OFS_KX1, icc_pkg::OFS_KX2, icc_pkg::OFS_KX3:
            begin
                wr_lo = 18'(signed'(cfg_q.slow)) - pct5;
                wr_hi = 18'(signed'(cfg_q.shigh)) + pct5;
            end
            icc_pkg::OFS_KY1, icc_pkg::OFS_KY2, icc_pkg::OFS_KY3, icc_pkg::OFS_BIAS:
            begin
                wr_lo = -span;
                wr_hi = span;
            end
            icc_pkg::OFS_CUT:
            begin
                wr_lo = '0;
                wr_hi = pct5;
            end
            icc_pkg::OFS_FILT:
            begin
                wr_lo = '0;
                wr_hi = 18'(icc_pkg::FILT_MAX_S);
            end
            icc_pkg::OFS_ROOT:
            begin
                wr_lo = '0;
                wr_hi = 18'sd1;
            end
            default:
            begin
                wr_lo = 18'sh20000;
            end
        endcase
        if (wr_val < wr_lo)
        begin
            wr_clamped = wr_lo[15:0];
        end
        else if (wr_val > wr_hi)
        begin
            wr_clamped = wr_hi[15:0];
        end
        else
        begin
            wr_clamped = wr_val[15:0];
        end
    end

    // register writes
    always_ff @(posedge clk_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            cfg_q.bias  <= icc_pkg::RST_ZERO;
            cfg_q.filt  <= icc_pkg::RST_ZERO;
            cfg_q.kx1   <= icc_pkg::RST_SLOW;
            cfg_q.ky1   <= icc_pkg::RST_ZERO;
            cfg_q.kx2   <= icc_pkg::RST_SLOW;
            cfg_q.ky2   <= icc_pkg::RST_ZERO;
            cfg_q.kx3   <= icc_pkg::RST_SLOW;
            cfg_q.ky3   <= icc_pkg::RST_ZERO;
            cfg_q.root  <= icc_pkg::RST_ZERO;
            cfg_q.cut   <= icc_pkg::RST_CUT;
            cfg_q.slow  <= icc_pkg::RST_SLOW;
            cfg_q.shigh <= icc_pkg::RST_SHIGH;
            cfg_q.itype <= icc_pkg::ITYPE_TC;
        end
        else if (reg_wr_in)
        begin
            unique case (reg_addr_in)
                icc_pkg::OFS_BIAS:  cfg_q.bias  <= wr_clamped;
                icc_pkg::OFS_FILT:  cfg_q.filt  <= wr_clamped;
                icc_pkg::OFS_KX1:   cfg_q.kx1   <= wr_clamped;
                icc_pkg::OFS_KY1:   cfg_q.ky1   <= wr_clamped;
                icc_pkg::OFS_KX2:   cfg_q.kx2   <= wr_clamped;
                icc_pkg::OFS_KY2:   cfg_q.ky2   <= wr_clamped;
                icc_pkg::OFS_KX3:   cfg_q.kx3   <= wr_clamped;
                icc_pkg::OFS_KY3:   cfg_q.ky3   <= wr_clamped;
                icc_pkg::OFS_ROOT:  cfg_q.root  <= wr_clamped;
                icc_pkg::OFS_CUT:   cfg_q.cut   <= wr_clamped;
                icc_pkg::OFS_SLOW:  cfg_q.slow  <= reg_wdata_in;
                icc_pkg::OFS_SHIGH: cfg_q.shigh <= reg_wdata_in;
                icc_pkg::OFS_ITYPE: cfg_q.itype <= reg_wdata_in[1:0];
                default:
                begin
                end
            endcase
        end
    end

    // register reads, data valid the cycle after the strobe
    always_ff @(posedge clk_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            reg_rdata_out <= '0;
        end
        else if (reg_rd_in)
        begin
            unique case (reg_addr_in)
                icc_pkg::OFS_BIAS:  reg_rdata_out <= cfg_q.bias;
                icc_pkg::OFS_FILT:  reg_rdata_out <= cfg_q.filt;
                icc_pkg::OFS_KX1:   reg_rdata_out <= cfg_q.kx1;
                icc_pkg::OFS_KY1:   reg_rdata_out <= cfg_q.ky1;
                icc_pkg::OFS_KX2:   reg_rdata_out <= cfg_q.kx2;
                icc_pkg::OFS_KY2:   reg_rdata_out <= cfg_q.ky2;
                icc_pkg::OFS_KX3:   reg_rdata_out <= cfg_q.kx3;
                icc_pkg::OFS_KY3:   reg_rdata_out <= cfg_q.ky3;
                icc_pkg::OFS_ROOT:  reg_rdata_out <= cfg_q.root;
                icc_pkg::OFS_CUT:   reg_rdata_out <= cfg_q.cut;
                icc_pkg::OFS_SLOW:  reg_rdata_out <= cfg_q.slow;
                icc_pkg::OFS_SHIGH: reg_rdata_out <= cfg_q.shigh;
                icc_pkg::OFS_ITYPE: reg_rdata_out <= {14'h0000, cfg_q.itype};
                icc_pkg::OFS_PV:    reg_rdata_out <= pv_out;
                icc_pkg::OFS_STAT:  reg_rdata_out <= {13'h0000, st_q};
                default:            reg_rdata_out <= '0;
            endcase
        end
        else
        begin
            reg_rdata_out <= '0;
        end
    end

    // segment choice, divider step, root trial and filter difference
    always_comb
    begin
        xa = sx(cfg_q.kx1);
        ya = sx(cfg_q.ky1);
        xb = sx(cfg_q.kx2);
        yb = sx(cfg_q.ky2);
        if (x_q >= sx(cfg_q.kx2))
        begin
            xa = sx(cfg_q.kx2);
            ya = sx(cfg_q.ky2);
            xb = sx(cfg_q.kx3);
            yb = sx(cfg_q.ky3);
        end
        prod      = (yb - ya) * (x_q - xa);
        div_trial = {div_rem_q[DW-2:0], div_num_q[DW-1]};
        div_quo   = div_neg_q ? -signed'(div_num_q) : signed'(div_num_q);
        sum       = x_q + val_q + sx(cfg_q.bias);
        rel       = sum - sx(cfg_q.slow);
        sq_try    = sq_res_q | (18'd1 << sq_bit_q);
        fdiff     = (val_q <<< FW) - acc_q;
    end

    // processing sequence
    always_ff @(posedge clk_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            st_q         <= icc_pkg::ST_IDLE;
            x_q          <= '0;
            val_q        <= '0;
            acc_q        <= '0;
            div_num_q    <= '0;
            div_den_q    <= '0;
            div_rem_q    <= '0;
            div_cnt_q    <= '0;
            div_neg_q    <= 1'b0;
            div_filt_q   <= 1'b0;
            sq_op_q      <= '0;
            sq_res_q     <= '0;
            sq_bit_q     <= '0;
            pv_out       <= '0;
            pv_valid_out <= 1'b0;
        end
        else
        begin
            pv_valid_out <= 1'b0;
            unique case (st_q)
                icc_pkg::ST_IDLE:
                begin
                    if (fifo_valid)
                    begin
                        x_q  <= sx(fifo_data);
                        st_q <= icc_pkg::ST_SEG;
                    end
                end
                icc_pkg::ST_SEG:
                begin
                    div_rem_q  <= '0;
                    div_cnt_q  <= '0;
                    div_filt_q <= 1'b0;
                    div_neg_q  <= prod < 0;
                    div_num_q  <= (prod < 0) ? DW'(-prod) : DW'(prod);
                    div_den_q  <= DW'(xb - xa);
                    if (x_q <= sx(cfg_q.kx1))
                    begin
                        val_q <= sx(cfg_q.ky1);
                        st_q  <= icc_pkg::ST_ADD;
                    end
                    else if (x_q >= sx(cfg_q.kx3) || xb == xa)
                    begin
                        val_q <= (x_q >= sx(cfg_q.kx3)) ? sx(cfg_q.ky3) : ya;
                        st_q  <= icc_pkg::ST_ADD;
                    end
                    else
                    begin
                        val_q <= ya;
                        st_q  <= icc_pkg::ST_DIV;
                    end
                end
                icc_pkg::ST_DIV:
                begin
                    if (div_trial >= div_den_q)
                    begin
                        div_rem_q <= div_trial - div_den_q;
                        div_num_q <= {div_num_q[DW-2:0], 1'b1};
                    end
                    else
                    begin
                        div_rem_q <= div_trial;
                        div_num_q <= {div_num_q[DW-2:0], 1'b0};
                    end
                    div_cnt_q <= div_cnt_q + 6'd1;
                    if (div_cnt_q == 6'(DW))
                    begin
                        div_num_q <= div_num_q;
                        div_rem_q <= div_rem_q;
                        if (div_filt_q)
                        begin
                            acc_q <= acc_q + div_quo;
                            st_q  <= icc_pkg::ST_OUT;
                        end
                        else
                        begin
                            val_q <= val_q + div_quo;
                            st_q  <= icc_pkg::ST_ADD;
                        end
                    end
                end
                icc_pkg::ST_ADD:
                begin
                    val_q    <= sum;
                    sq_op_q  <= 36'(rel) * 36'(signed'(DW'(span)));
                    sq_res_q <= '0;
                    sq_bit_q <= 5'(icc_pkg::SQ_W - 1);
                    st_q     <= icc_pkg::ST_FILT;
                    if (cfg_q.root == 16'h0001 && cfg_q.itype == icc_pkg::ITYPE_DCV
                        && rel >= sx(cfg_q.cut))
                    begin
                        st_q <= icc_pkg::ST_ROOT;
                    end
                end
                icc_pkg::ST_ROOT:
                begin
                    if (36'(sq_try) * 36'(sq_try) <= sq_op_q)
                    begin
                        sq_res_q <= sq_try;
                    end
                    sq_bit_q <= sq_bit_q - 5'd1;
                    if (sq_bit_q == '0)
                    begin
                        val_q <= sx(cfg_q.slow) + DW'(sq_try * 36'(sq_try) <= sq_op_q
                                 ? sq_try : sq_res_q);
                        st_q  <= icc_pkg::ST_FILT;
                    end
                end
                icc_pkg::ST_FILT:
                begin
                    div_rem_q  <= '0;
                    div_cnt_q  <= '0;
                    div_filt_q <= 1'b1;
                    div_neg_q  <= fdiff < 0;
                    div_num_q  <= DW'((fdiff < 0 ? -fdiff : fdiff) * icc_pkg::SAMPLE_MS);
                    div_den_q  <= DW'(cfg_q.filt) * DW'(icc_pkg::MS_PER_S)
                                  + DW'(icc_pkg::SAMPLE_MS);
                    if (cfg_q.filt == '0)
                    begin
                        acc_q <= val_q <<< FW;
                        st_q  <= icc_pkg::ST_OUT;
                    end
                    else
                    begin
                        st_q <= icc_pkg::ST_DIV;
                    end
                end
                icc_pkg::ST_OUT:
                begin
                    pv_out       <= sat16(acc_q >>> FW);
                    pv_valid_out <= 1'b1;
                    st_q         <= icc_pkg::ST_IDLE;
                end
                default:
                begin
                    st_q <= icc_pkg::ST_IDLE;
                end
            endcase
        end
    end
endmodule // icc_input_correction_chain
`default_nettype wire

//--- test/icc_properties.sv
// port checker for the input correction chain
`default_nettype none
module icc_properties (
    // clock and reset
    input wire logic        clk_in,
    input wire logic        reset_in,
    // register port
    input wire logic [7:0]  reg_addr_in,
    input wire logic [15:0] reg_wdata_in,
    input wire logic        reg_wr_in,
    input wire logic        reg_rd_in,
    input wire logic [15:0] reg_rdata_out,
    // stream
    input wire logic [15:0] smp_data_in,
    input wire logic        smp_valid_in,
    input wire logic        smp_ready_out,
    input wire logic [15:0] pv_out,
    input wire logic        pv_valid_out
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (reset_in);
    // samples taken but not yet answered
    int pend_q;
    sequence s_read(logic [7:0] a);
        reg_rd_in && reg_addr_in == a ##1 1'b1;
    endsequence
    always_ff @(posedge clk_in or posedge reset_in)
        if (reset_in)
            pend_q <= 0;
        else
            pend_q <= pend_q + int'(smp_valid_in && smp_ready_out) - int'(pv_valid_out);
    a_rdata_idle_zero: assert property (!reg_rd_in |=> reg_rdata_out == 16'h0000)
        else $error("read data not idle");
    a_unmapped_reads_zero: assert property (s_read(8'hc0) |-> reg_rdata_out == 16'h0000)
        else $error("unmapped read not zero");
    a_pv_read_back: assert property (s_read(8'hb8) |-> reg_rdata_out == $past(pv_out))
        else $error("pv readback wrong");
    a_pv_single_pulse: assert property (pv_valid_out |=> !pv_valid_out [*4])
        else $error("pv pulses too close");
    a_pv_value_holds: assert property (!pv_valid_out |-> $stable(pv_out))
        else $error("pv moved without pulse");
    a_ready_after_reset: assert property ($fell(reset_in) |-> ##1 smp_ready_out)
        else $error("ready late after reset");
    a_full_needs_push: assert property ($fell(smp_ready_out) |-> $past(smp_valid_in))
        else $error("ready fell without push");
    a_pv_needs_sample: assert property (pv_valid_out |-> pend_q > 0)
        else $error("pv without sample");
endmodule // icc_properties
bind icc_input_correction_chain icc_properties i_props (.clk_in, .reset_in, .reg_addr_in,
    .reg_wdata_in, .reg_wr_in, .reg_rd_in, .reg_rdata_out, .smp_data_in, .smp_valid_in,
    .smp_ready_out, .pv_out, .pv_valid_out);
`default_nettype wire

//--- test/icc_loop_partner.sv
// sensor sample source and process value sink
`default_nettype none
module icc_loop_partner (
    // clock and reset
    input  wire logic        clk_in,
    input  wire logic        reset_in,
    // sample side
    input  wire logic        stall_in,
    input  wire logic        smp_ready_in,
    output logic [15:0]      smp_data_out,
    output logic             smp_valid_out,
    // process value side
    input  wire logic [15:0] pv_in,
    input  wire logic        pv_valid_in
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [15:0] q[$];
    logic [15:0] got[$];
    // offer held until taken; idle data inverted each cycle
    always @(posedge clk_in or posedge reset_in)
        if (reset_in)
        begin
            smp_valid_out <= 1'b0;
            smp_data_out  <= 16'h0000;
        end
        else if (!smp_valid_out || smp_ready_in)
        begin
            if (smp_valid_out)
                void'(q.pop_front());
            smp_valid_out <= q.size() > 0 && !stall_in;
            smp_data_out  <= (q.size() > 0 && !stall_in) ? q[0] : ~smp_data_out;
        end
    always @(posedge clk_in)
        if (pv_valid_in)
            got.push_back(pv_in);
endmodule // icc_loop_partner
`default_nettype wire

//--- test/icc_input_correction_chain_tb_top.sv
// testbench for the input correction chain
`default_nettype none
module icc_input_correction_chain_tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    logic        clk_in = 1'b0;
    logic        reset_in = 1'b1;
    logic [7:0]  reg_addr_in = 8'h00;
    logic [15:0] reg_wdata_in = 16'h0000;
    logic        reg_wr_in = 1'b0;
    logic        reg_rd_in = 1'b0;
    logic        stall = 1'b0;
    logic        saw_full = 1'b0;
    logic [15:0] reg_rdata_out, smp_data_in, pv_out;
    logic        smp_valid_in, smp_ready_out, pv_valid_out;
    int          n_fail = 0;
    int          comparisons = 0;
    logic [15:0] exp_q[$];
    always #12.5 clk_in = ~clk_in;
    always @(posedge clk_in)
        if (smp_valid_in && !smp_ready_out)
            saw_full <= 1'b1;
    icc_input_correction_chain i_dut (.clk_in, .reset_in, .reg_addr_in, .reg_wdata_in,
        .reg_wr_in, .reg_rd_in, .reg_rdata_out, .smp_data_in, .smp_valid_in, .smp_ready_out,
        .pv_out, .pv_valid_out);
    icc_loop_partner i_src (.clk_in, .reset_in, .stall_in(stall),
        .smp_ready_in(smp_ready_out), .smp_data_out(smp_data_in),
        .smp_valid_out(smp_valid_in), .pv_in(pv_out), .pv_valid_in(pv_valid_out));
    task automatic give_verdict();
        $display("comparisons %0d n_fail %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
        comparisons++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk_in);
        reg_addr_in  <= a;
        reg_wdata_in <= d;
        reg_wr_in    <= 1'b1;
        @(posedge clk_in);
        reg_wr_in    <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [15:0] e);
        @(posedge clk_in);
        reg_addr_in <= a;
        reg_rd_in   <= 1'b1;
        @(posedge clk_in);
        reg_rd_in   <= 1'b0;
        #1 chk(reg_rdata_out, e, "register");
    endtask
    task automatic wait_pv(input int n);
        int k;
        for (k = 0; k < 4000 && i_src.got.size() < n; k++)
            @(posedge clk_in);
        if (k == 4000)
        begin
            n_fail++;
            give_verdict();
        end
    endtask
    task automatic xs(input logic [15:0] v, input logic [15:0] e);
        i_src.q.push_back(v);
        exp_q.push_back(e);
    endtask
    task automatic drain();
        wait_pv(exp_q.size());
        while (exp_q.size() > 0)
            chk(i_src.got.pop_front(), exp_q.pop_front(), "pv");
    endtask
    task automatic t_regs();
        logic [39:0] t [8] = '{40'hac_00c8_0078, 40'hb4_0200_01f4, 40'had_8000_fe0c,
            40'hae_8000_d8f0, 40'hb1_7fff_2904, 40'hab_7fff_2710, 40'hb3_0005_0001,
            40'hc0_1234_0000};
        for (logic [7:0] a = 8'hab; a <= 8'hb9; a++)
            rd(a, (a == 8'hb4) ? 16'h0064 : (a == 8'hb6) ? 16'h2710 : 16'h0000);
        for (int i = 0; i < 8; i++)
        begin
            wr(t[i][39:32], t[i][31:16]);
            rd(t[i][39:32], t[i][15:0]);
            wr(t[i][39:32], (t[i][39:32] == 8'hb4) ? 16'h0064 : 16'h0000);
        end
        $display("test registers done");
    endtask
    task automatic t_bias();
        wr(8'hab, 16'h0064);
        stall <= 1'b1;
        @(posedge clk_in);
        for (int i = 0; i < 12; i++)
            xs(16'(i * 300), 16'(i * 300 + 100));
        xs(16'hff00, 16'hff64);
        stall <= 1'b0;
        drain();
        chk({15'h0000, saw_full}, 16'h0001, "fifo full");
        rd(8'hb8, 16'hff64);
        wr(8'hab, 16'h0000);
        $display("test fixed bias done");
    endtask
    task automatic t_knee();
        logic [31:0] k [6] = '{32'had_03e8, 32'hae_0064, 32'haf_07d0, 32'hb0_012c,
            32'hb1_0bb8, 32'hb2_ff9c};
        foreach (k[i])
            wr(k[i][23:16], k[i][15:0]);
        xs(16'h01f4, 16'h0258);
        xs(16'h03e8, 16'h044c);
        xs(16'h05dc, 16'h06a4);
        xs(16'h07d0, 16'h08fc);
        xs(16'h09c4, 16'h0a28);
        xs(16'h0fa0, 16'h0f3c);
        drain();
        foreach (k[i])
            wr(k[i][23:16], 16'h0000);
        $display("test broken line done");
    endtask
    task automatic t_root();
        wr(8'hb3, 16'h0001);
        xs(16'h09c4, 16'h09c4);
        drain();
        wr(8'hb7, 16'h0002);
        xs(16'h09c4, 16'h1388);
        xs(16'h0032, 16'h0032);
        xs(16'h0064, 16'h03e8);
        drain();
        wr(8'hab, 16'h0190);
        xs(16'h0834, 16'h1388);
        drain();
        wr(8'hab, 16'h0000);
        wr(8'hb3, 16'h0000);
        xs(16'h09c4, 16'h09c4);
        drain();
        wr(8'hb7, 16'h0000);
        $display("test root done");
    endtask
    task automatic t_filter();
        logic [15:0] p [3];
        wr(8'hac, 16'h0001);
        for (int i = 0; i < 3; i++)
        begin
            if (i == 2)
                wr(8'hac, 16'h0078);
            i_src.q.push_back((i == 2) ? 16'h0000 : 16'h1770);
            wait_pv(1);
            p[i] = i_src.got.pop_front();
        end
        chk({15'h0000, p[0] > 0 && p[0] < p[1] && p[1] < 16'h1770}, 16'h0001, "lag");
        chk({15'h0000, p[2] < p[1] && p[2] > p[1] - p[1] / 16}, 16'h0001, "slow");
        wr(8'hac, 16'h0000);
        xs(16'h1770, 16'h1770);
        drain();
        $display("test filter done");
    endtask
    initial
    begin
        repeat (4) @(posedge clk_in);
        reset_in <= 1'b0;
        repeat (2) @(posedge clk_in);
        t_regs();
        t_bias();
        t_knee();
        t_root();
        t_filter();
        give_verdict();
    end
endmodule // icc_input_correction_chain_tb_top
`default_nettype wire
